// ### tou_ctrl.sv
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module tou_ctrl
  import tou_pkg::*;
#(
  parameter int unsigned BLINK_CYCLES = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS
)
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_B,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // board switches
  input  wire logic        PACKET_SIZE_SWITCH,
  input  wire logic        DIRECTION_SELECT_SWITCH,
  input  wire logic        START_BUTTON,
  // core register port
  output logic             CORE_WR,
  output logic [3:0]       CORE_ADDR,
  output logic [63:0]      CORE_WDATA,
  input  wire logic [63:0] CORE_RDATA,
  input  wire logic        CONNECTION_ACTIVE,
  // core transmit fifo port
  output logic             TXF_WREN,
  output logic [31:0]      TXF_WDATA,
  input  wire logic        TXF_FULL,
  // core receive fifo port
  output logic             RXF_RDEN,
  input  wire logic [31:0] RXF_RDATA,
  input  wire logic        RXF_EMPTY,
  // indicators
  output logic             VERIFY_FAIL_LED,
  output logic             IRQ
);

  typedef struct packed {
    tou_state_t  state;
    logic [1:0]  pidx;
    logic [1:0]  settle;
    logic [3:0]  chunks;
    logic [31:0] tx_pat;
    logic [11:0] tx_cnt;
    logic        txf_wren;
    logic [31:0] rx_pat;
    logic        rden;
    logic        rvalid;
    logic        err;
    logic [31:0] blink_cnt;
    logic        led;
    logic [31:0] rx_words;
    logic [3:0]  irq_st;
    logic [3:0]  irq_mask;
    logic        irq;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        start_req;
    tou_op_t     op;
  } tou_regs_t;

  tou_regs_t s_r;
  tou_regs_t s_nxt;

  // register address and write value come straight from the state
  function automatic tou_op_t tou_decode(tou_state_t st, logic [1:0] idx, logic jumbo);
    tou_op_t o;
    o = '{wr: 1'b0, addr: CORE_CMD_ADDR, data: CMD_SEND_VAL};
    unique case (st)
      ST_IDLE:       o = '{wr: 1'b1, addr: CORE_RST_ADDR, data: RST_ON_VAL};
      ST_SET_PARAM:
        unique case (idx)
          2'h0: o = '{wr: 1'b1, addr: CORE_SMAC_ADDR, data: SMAC_VAL};
          2'h1: o = '{wr: 1'b1, addr: CORE_SIP_ADDR, data: SIP_VAL};
          2'h2: o = '{wr: 1'b1, addr: CORE_SPORT_ADDR, data: SPORT_VAL};
          2'h3: o = '{wr: 1'b1, addr: CORE_DIP_ADDR, data: DIP_VAL};
        endcase
      ST_RELEASE:    o = '{wr: 1'b1, addr: CORE_RST_ADDR, data: RST_OFF_VAL};
      ST_TX_LEN:     o = '{wr: 1'b1, addr: CORE_TDL_ADDR, data: TDL_VAL};
      ST_TX_PKT_LEN: o = '{wr: 1'b1, addr: CORE_PKL_ADDR, data: jumbo ? PKL_JUMBO_VAL : PKL_STD_VAL};
      ST_TX_CMD:     o = '{wr: 1'b1, addr: CORE_CMD_ADDR, data: CMD_SEND_VAL};
      ST_TX_CLOSE:   o = '{wr: 1'b1, addr: CORE_CMD_ADDR, data: CMD_CLOSE_VAL};
      default:       o = '{wr: 1'b0, addr: CORE_CMD_ADDR, data: CMD_SEND_VAL};
    endcase
    return o;
  endfunction

  // apb offsets that answer without error
  function automatic logic tou_mapped(logic [7:0] a);
    return (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_IRQ_STAT) ||
           (a == REG_IRQ_MASK) || (a == REG_RX_WORDS) || (a == REG_CHUNKS);
  endfunction

  logic        busy;
  logic        tx_active;
  logic        pkt_end;
  logic [11:0] words_last;
  logic        apb_wr;
  logic        apb_rd;
  logic [3:0]  ev;

  assign busy = CORE_RDATA[CORE_BUSY_BIT];
  assign tx_active = (s_r.state == ST_TX_LEN) || (s_r.state == ST_TX_PKT_LEN) ||
                     (s_r.state == ST_TX_CMD) || (s_r.state == ST_XFER_WAIT);
  assign words_last = (PACKET_SIZE_SWITCH ? WORDS_JUMBO : WORDS_STD) - 12'h001;
  assign pkt_end = s_r.txf_wren && (s_r.tx_cnt == words_last);
  assign apb_wr = PSEL && PENABLE && s_r.pready && PWRITE;
  assign apb_rd = PSEL && PENABLE && s_r.pready && !PWRITE;

  // next state of everything
  always_comb
  begin
    s_nxt = s_r;
    ev = 4'h0;
    // control state machine
    unique case (s_r.state)
      ST_IDLE:
      begin
        s_nxt.pidx = 2'h0;
        if (START_BUTTON || s_r.start_req)
        begin
          s_nxt.state = ST_SET_PARAM;
          s_nxt.start_req = 1'b0;
        end
      end
      ST_SET_PARAM:
      begin
        s_nxt.pidx = s_r.pidx + 2'h1;
        if (s_r.pidx == 2'h3)
          s_nxt.state = ST_RELEASE;
      end
      ST_RELEASE:
      begin
        s_nxt.state = ST_INIT_WAIT;
        s_nxt.settle = SETTLE_CYC;
      end
      ST_INIT_WAIT:
        // busy lags the write, so skip a couple of polls
        if (s_r.settle != 2'h0)
          s_nxt.settle = s_r.settle - 2'h1;
        else if (!busy)
          s_nxt.state = ST_OPEN_WAIT;
      ST_OPEN_WAIT:
        if (CONNECTION_ACTIVE)
        begin
          ev[IRQ_OPEN] = 1'b1;
          s_nxt.chunks = 4'h0;
          s_nxt.state = DIRECTION_SELECT_SWITCH ? ST_TX_LEN : ST_CLOSE_WAIT;
        end
      ST_TX_LEN:
        s_nxt.state = ST_TX_PKT_LEN;
      ST_TX_PKT_LEN:
        s_nxt.state = ST_TX_CMD;
      ST_TX_CMD:
      begin
        s_nxt.state = ST_XFER_WAIT;
        s_nxt.settle = SETTLE_CYC;
      end
      ST_XFER_WAIT:
        if (s_r.settle != 2'h0)
          s_nxt.settle = s_r.settle - 2'h1;
        else if (!busy)
        begin
          s_nxt.chunks = s_r.chunks + 4'h1;
          s_nxt.state = (s_r.chunks == 4'(CHUNK_COUNT - 1)) ? ST_TX_CLOSE : ST_TX_CMD;
        end
      ST_TX_CLOSE:
      begin
        s_nxt.state = ST_CLOSE_BUSY;
        s_nxt.settle = SETTLE_CYC;
      end
      ST_CLOSE_BUSY:
        if (s_r.settle != 2'h0)
          s_nxt.settle = s_r.settle - 2'h1;
        else if (!busy && !CONNECTION_ACTIVE)
        begin
          ev[IRQ_TX_DONE] = 1'b1;
          s_nxt.state = ST_OPEN_WAIT;
        end
      ST_CLOSE_WAIT:
        if (!CONNECTION_ACTIVE)
        begin
          ev[IRQ_RX_DONE] = 1'b1;
          s_nxt.state = ST_OPEN_WAIT;
        end
      default:
        s_nxt.state = ST_IDLE;
    endcase
    s_nxt.op = tou_decode(s_r.state, s_r.pidx, PACKET_SIZE_SWITCH);

    // transmit pattern; full must be an almost-full with a word of margin
    s_nxt.txf_wren = tx_active && !TXF_FULL;
    if (s_r.txf_wren)
      s_nxt.tx_cnt = pkt_end ? 12'h000 : s_r.tx_cnt + 12'h001;
    if (pkt_end)
      s_nxt.tx_pat = s_r.tx_pat + 32'h0000_0001;

    // receive read and verify; one read in flight keeps empty honest
    s_nxt.rden = !RXF_EMPTY && !s_r.rden;
    s_nxt.rvalid = s_r.rden;
    if (s_r.rvalid)
    begin
      s_nxt.rx_pat = s_r.rx_pat + 32'h0000_0001;
      s_nxt.rx_words = s_r.rx_words + 32'h0000_0001;
      if (RXF_RDATA != s_r.rx_pat)
      begin
        s_nxt.err = 1'b1;
        ev[IRQ_VERIFY] = 1'b1;
      end
    end

    // blink only after an error
    if (s_r.err)
    begin
      if (s_r.blink_cnt >= BLINK_CYCLES - 1)
      begin
        s_nxt.blink_cnt = 32'h0000_0000;
        s_nxt.led = !s_r.led;
      end
      else
        s_nxt.blink_cnt = s_r.blink_cnt + 32'h0000_0001;
    end

    // apb: answer registered in the setup cycle, zero wait states
    s_nxt.pready = PSEL && !PENABLE;
    s_nxt.pslverr = PSEL && !PENABLE && !tou_mapped(PADDR);
    s_nxt.prdata = 32'h0000_0000;
    if (PSEL && !PENABLE && !PWRITE)
      unique case (PADDR)
        REG_CTRL:     s_nxt.prdata = {31'h0000_0000, s_r.start_req};
        REG_STATUS:   s_nxt.prdata = {24'h00_0000, s_r.err, CONNECTION_ACTIVE, 2'h0, s_r.state};
        REG_IRQ_STAT: s_nxt.prdata = {28'h000_0000, s_r.irq_st};
        REG_IRQ_MASK: s_nxt.prdata = {28'h000_0000, s_r.irq_mask};
        REG_RX_WORDS: s_nxt.prdata = s_r.rx_words;
        REG_CHUNKS:   s_nxt.prdata = {28'h000_0000, s_r.chunks};
        default:      s_nxt.prdata = 32'h0000_0000;
      endcase
    if (apb_wr && (PADDR == REG_CTRL) && PWDATA[0])
      s_nxt.start_req = 1'b1;
    if (apb_wr && (PADDR == REG_IRQ_MASK))
      s_nxt.irq_mask = PWDATA[3:0];

    // sticky status, read clears, a new event wins over the clear
    if (apb_rd && (PADDR == REG_IRQ_STAT))
      s_nxt.irq_st = ev;
    else
      s_nxt.irq_st = s_r.irq_st | ev;
    s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_mask);
  end

  // single state register; reset gives idle with core held in reset
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      s_r <= '{state: ST_IDLE, op: '{wr: 1'b0, addr: CORE_RST_ADDR, data: RST_ON_VAL},
               default: '0};
    else
      s_r <= s_nxt;
  end

  // outputs straight from the state register
  assign PRDATA = s_r.prdata;
  assign PREADY = s_r.pready;
  assign PSLVERR = s_r.pslverr;
  assign CORE_WR = s_r.op.wr;
  assign CORE_ADDR = s_r.op.addr;
  assign CORE_WDATA = s_r.op.data;
  assign TXF_WREN = s_r.txf_wren;
  assign TXF_WDATA = s_r.tx_pat;
  assign RXF_RDEN = s_r.rden;
  assign VERIFY_FAIL_LED = s_r.led;
  assign IRQ = s_r.irq;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  property p_tx_step;
    pkt_end |=> (s_r.tx_pat == $past(s_r.tx_pat) + 32'h0000_0001) && (s_r.tx_cnt == 12'h000);
  endproperty
  a_tx_step: assert property (p_tx_step) else $error("tx pattern did not step at packet end");

  property p_tx_hold;
    (s_r.txf_wren && !pkt_end) |=> $stable(s_r.tx_pat);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx pattern changed inside a packet");

  property p_pkt_len;
    (s_r.state == ST_TX_PKT_LEN) |=> CORE_WR && (CORE_ADDR == CORE_PKL_ADDR) &&
      (CORE_WDATA == ($past(PACKET_SIZE_SWITCH) ? PKL_JUMBO_VAL : PKL_STD_VAL));
  endproperty
  a_pkt_len: assert property (p_pkt_len) else $error("wrong packet length written");

  property p_rx_step;
    s_r.rvalid |=> (s_r.rx_pat == $past(s_r.rx_pat) + 32'h0000_0001);
  endproperty
  a_rx_step: assert property (p_rx_step) else $error("rx expected pattern did not step");

  property p_rx_read;
    (!RXF_EMPTY && !RXF_RDEN) |=> RXF_RDEN ##1 !RXF_RDEN;
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("receive fifo not read when not empty");

  property p_err;
    (s_r.rvalid && (RXF_RDATA != s_r.rx_pat)) |=> s_r.err;
  endproperty
  a_err: assert property (p_err) else $error("mismatch did not raise the error flag");

  property p_start;
    ((s_r.state == ST_IDLE) && START_BUTTON) |=> (s_r.state == ST_SET_PARAM);
  endproperty
  a_start: assert property (p_start) else $error("start button did not leave idle");

  property p_release;
    (s_r.state == ST_RELEASE) |=> CORE_WR && (CORE_ADDR == CORE_RST_ADDR) && (CORE_WDATA == RST_OFF_VAL);
  endproperty
  a_release: assert property (p_release) else $error("core reset not released");

  property p_open_dir;
    ((s_r.state == ST_OPEN_WAIT) && CONNECTION_ACTIVE) |=>
      (s_r.state == ($past(DIRECTION_SELECT_SWITCH) ? ST_TX_LEN : ST_CLOSE_WAIT));
  endproperty
  a_open_dir: assert property (p_open_dir) else $error("wrong state after connection opened");

  property p_close_cmd;
    (s_r.state == ST_TX_CLOSE) |=> CORE_WR && (CORE_ADDR == CORE_CMD_ADDR) && (CORE_WDATA == CMD_CLOSE_VAL);
  endproperty
  a_close_cmd: assert property (p_close_cmd) else $error("close command not written");

  property p_rx_close;
    ((s_r.state == ST_CLOSE_WAIT) && !CONNECTION_ACTIVE) |=> (s_r.state == ST_OPEN_WAIT);
  endproperty
  a_rx_close: assert property (p_rx_close) else $error("no return to open wait after close");

  property p_params;
    ((s_r.state == ST_SET_PARAM) && (s_r.pidx == 2'h0)) |=>
      (CORE_WR && (CORE_ADDR == CORE_SMAC_ADDR) && (CORE_WDATA == SMAC_VAL)) ##1
      (CORE_WR && (CORE_ADDR == CORE_SIP_ADDR) && (CORE_WDATA == SIP_VAL)) ##1
      (CORE_WR && (CORE_ADDR == CORE_SPORT_ADDR) && (CORE_WDATA == SPORT_VAL)) ##1
      (CORE_WR && (CORE_ADDR == CORE_DIP_ADDR) && (CORE_WDATA == DIP_VAL));
  endproperty
  a_params: assert property (p_params) else $error("network parameters not written in turn");

  property p_init_busy;
    ((s_r.state == ST_INIT_WAIT) && (s_r.settle == 2'h0) && busy) |=> (s_r.state == ST_INIT_WAIT);
  endproperty
  a_init_busy: assert property (p_init_busy) else $error("left init wait while core busy");

  property p_tx_seq;
    (s_r.state == ST_TX_LEN) |=>
      (CORE_WR && (CORE_ADDR == CORE_TDL_ADDR) && (CORE_WDATA == TDL_VAL)) ##1
      (CORE_WR && (CORE_ADDR == CORE_PKL_ADDR)) ##1
      (CORE_WR && (CORE_ADDR == CORE_CMD_ADDR) && (CORE_WDATA == CMD_SEND_VAL));
  endproperty
  a_tx_seq: assert property (p_tx_seq) else $error("transmit setup writes out of order");

  property p_chunk;
    ((s_r.state == ST_XFER_WAIT) && (s_r.settle == 2'h0) && !busy) |=>
      (s_r.chunks == $past(s_r.chunks) + 4'h1) && ((s_r.state == ST_TX_CLOSE) == (s_r.chunks == 4'(CHUNK_COUNT)));
  endproperty
  a_chunk: assert property (p_chunk) else $error("chunk count or resend decision wrong");

  property p_close_done;
    ((s_r.state == ST_CLOSE_BUSY) && (s_r.settle == 2'h0) && !busy && !CONNECTION_ACTIVE) |=>
      (s_r.state == ST_OPEN_WAIT);
  endproperty
  a_close_done: assert property (p_close_done) else $error("no return to open wait after active close");

endmodule

// ### tou_pkg.sv
// Overview of operation
// - transmit word is 32 bits, advancing by one only when a packet ends
// - transmit packet counter length picked by switch: 1456 or 8960 bytes
// - receive expected word advances by one on every word read
// - read the receive FIFO whenever it is not empty; compare each word (code reads at most every other cycle, skipping the cycle after a read)
// - any mismatching received word makes the fail LED blink
// - state decodes core address and data; start button leaves idle
// - write source MAC, source IP, source port and destination IP
// - then write zero to the core reset register
// - poll busy at bit 0 of the command register until clear
// - wait passively for the remote client to open the connection
// - on connection go to transmit length or, in receive mode, close wait
// - transmit: write total length, packet length, then command zero
// - wait busy clear per 4GB chunk; resend until 32 GB sent
// - after all chunks write 0x3 to the command register to close
// - when closed and not busy, return to open wait
// - receive: stay in close wait until connection drops, then open wait
package tou_pkg;

  // core register map, 4-bit address, 64-bit data
  localparam logic [3:0]  CORE_RST_ADDR = 4'h0;
  localparam logic [3:0]  CORE_CMD_ADDR = 4'h1;
  localparam logic [3:0]  CORE_SMAC_ADDR = 4'h2;
  localparam logic [3:0]  CORE_SIP_ADDR = 4'h3;
  localparam logic [3:0]  CORE_SPORT_ADDR = 4'h4;
  localparam logic [3:0]  CORE_DIP_ADDR = 4'h5;
  localparam logic [3:0]  CORE_TDL_ADDR = 4'h6;
  localparam logic [3:0]  CORE_PKL_ADDR = 4'h7;
  localparam int          CORE_BUSY_BIT = 0;

  // network parameters and command values
  localparam logic [63:0] SMAC_VAL = 64'h0000_0001_0203_0405;
  localparam logic [63:0] SIP_VAL = 64'h0000_0000_c0a8_072a;
  localparam logic [63:0] SPORT_VAL = 64'h0000_0000_0000_0fa0;
  localparam logic [63:0] DIP_VAL = 64'h0000_0000_c0a8_0719;
  localparam logic [63:0] TDL_VAL = 64'h0000_0001_0000_0000;
  localparam logic [63:0] PKL_STD_VAL = 64'h0000_0000_0000_05b0;
  localparam logic [63:0] PKL_JUMBO_VAL = 64'h0000_0000_0000_2300;
  localparam logic [63:0] CMD_SEND_VAL = 64'h0000_0000_0000_0000;
  localparam logic [63:0] CMD_CLOSE_VAL = 64'h0000_0000_0000_0003;
  localparam logic [63:0] RST_ON_VAL = 64'h0000_0000_0000_0001;
  localparam logic [63:0] RST_OFF_VAL = 64'h0000_0000_0000_0000;

  // words per packet: bytes / 4
  localparam logic [11:0] WORDS_STD = 12'h16c;
  localparam logic [11:0] WORDS_JUMBO = 12'h8c0;
  localparam int          CHUNK_COUNT = 8;
  localparam logic [1:0]  SETTLE_CYC = 2'h2;

  // led blink half period
  localparam int          BLINK_HALF_MS = 250;
  localparam int          CLK_PERIOD_NS = 4;

  // apb register byte offsets
  localparam logic [7:0]  REG_CTRL = 8'h00;
  localparam logic [7:0]  REG_STATUS = 8'h04;
  localparam logic [7:0]  REG_IRQ_STAT = 8'h08;
  localparam logic [7:0]  REG_IRQ_MASK = 8'h0c;
  localparam logic [7:0]  REG_RX_WORDS = 8'h10;
  localparam logic [7:0]  REG_CHUNKS = 8'h14;

  // interrupt status bit positions
  localparam int          IRQ_VERIFY = 0;
  localparam int          IRQ_OPEN = 1;
  localparam int          IRQ_TX_DONE = 2;
  localparam int          IRQ_RX_DONE = 3;

  typedef enum logic [3:0] {
    ST_IDLE       = 4'h0,
    ST_SET_PARAM  = 4'h1,
    ST_RELEASE    = 4'h2,
    ST_INIT_WAIT  = 4'h3,
    ST_OPEN_WAIT  = 4'h4,
    ST_TX_LEN     = 4'h5,
    ST_TX_PKT_LEN = 4'h6,
    ST_TX_CMD     = 4'h7,
    ST_XFER_WAIT  = 4'h8,
    ST_TX_CLOSE   = 4'h9,
    ST_CLOSE_BUSY = 4'ha,
    ST_CLOSE_WAIT = 4'hb
  } tou_state_t;

  typedef struct packed {
    logic        wr;
    logic [3:0]  addr;
    logic [63:0] data;
  } tou_op_t;

endpackage

// ### tou_core_model.sv
`timescale 1ns/10ps
module tou_core_model
  import tou_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_B,
  // register port
  input  wire logic        CORE_WR,
  input  wire logic [3:0]  CORE_ADDR,
  input  wire logic [63:0] CORE_WDATA,
  output logic [63:0]      CORE_RDATA,
  output logic             CONNECTION_ACTIVE,
  // fifo ports
  input  wire logic        TXF_WREN,
  input  wire logic [31:0] TXF_WDATA,
  output logic             TXF_FULL,
  input  wire logic        RXF_RDEN,
  output logic [31:0]      RXF_RDATA,
  output logic             RXF_EMPTY,
  // bench control
  input  wire logic        open_req,
  input  wire logic        close_req,
  input  wire logic [15:0] busy_len,
  input  wire logic [15:0] rx_add,
  input  wire logic [31:0] bad_at
);
  logic [63:0] regs [16];
  logic [31:0] tx_exp;
  logic [31:0] rx_seq;
  logic [2:0]  tick;
  logic        close_pend;
  logic        tdl_seen;
  logic        pkl_seen;
  int          busy_cnt;
  int          rx_left;
  int          pkt_pos;
  int          n_send;
  int          n_close;
  int          n_err;
  int          n_words;
  int          n_wr_busy;
  int          n_order;

  // busy only on the command register, other reads return the stored value
  assign CORE_RDATA = (CORE_ADDR == CORE_CMD_ADDR) ? {63'h0, busy_cnt != 0} : regs[CORE_ADDR];
  assign RXF_EMPTY  = (rx_left == 0);
  assign TXF_FULL   = (tick == 3'h7); // periodic stall, the slow case

  // behavioural core: busy timing, connection, fifo traffic
  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      foreach (regs[i]) regs[i] <= 64'h0;
      {tx_exp, rx_seq, tick, close_pend, tdl_seen, pkl_seen} <= '0;
      {busy_cnt, rx_left, pkt_pos, n_send, n_close, n_err, n_words, n_wr_busy, n_order} <= '0;
      CONNECTION_ACTIVE <= 1'b0;
      RXF_RDATA <= 32'h0;
    end
    else
    begin
      tick <= tick + 3'h1;
      if (busy_cnt != 0)
        busy_cnt <= busy_cnt - 1;
      if (open_req) // remote client opens
        CONNECTION_ACTIVE <= 1'b1;
      if (close_req || (close_pend && busy_cnt == 0)) // remote or active close
      begin
        CONNECTION_ACTIVE <= 1'b0;
        close_pend <= 1'b0;
        tdl_seen <= 1'b0;
        pkl_seen <= 1'b0;
      end
      if (CORE_WR)
      begin
        if (busy_cnt != 0 && CORE_ADDR != CORE_RST_ADDR)
          n_wr_busy <= n_wr_busy + 1;
        regs[CORE_ADDR] <= CORE_WDATA;
        if (CORE_ADDR == CORE_RST_ADDR && CORE_WDATA == 64'h0 && regs[0] != 64'h0)
          busy_cnt <= busy_len;
        if (CORE_ADDR == CORE_TDL_ADDR)
          tdl_seen <= 1'b1;
        if (CORE_ADDR == CORE_PKL_ADDR)
          pkl_seen <= tdl_seen;
        if (CORE_ADDR == CORE_CMD_ADDR)
        begin
          busy_cnt <= busy_len;
          if (CORE_WDATA[1:0] == 2'h3)
          begin
            n_close <= n_close + 1;
            close_pend <= 1'b1;
          end
          else
          begin
            n_send <= n_send + 1;
            n_order <= n_order + (pkl_seen ? 0 : 1);
          end
        end
      end
      // remote receiver: one value per packet, any stray word flagged
      if (TXF_WREN)
      begin
        n_words <= n_words + 1;
        if (TXF_WDATA !== tx_exp)
          n_err <= n_err + 1;
        if (64'(pkt_pos + 1) == (regs[CORE_PKL_ADDR] >> 2))
        begin
          pkt_pos <= 0;
          tx_exp <= tx_exp + 32'h1;
        end
        else
          pkt_pos <= pkt_pos + 1;
      end
      // read data valid one cycle, then scrambled so stale data never matches
      if (RXF_RDEN && rx_left != 0)
      begin
        RXF_RDATA <= (rx_seq == bad_at) ? ~rx_seq : rx_seq;
        rx_seq <= rx_seq + 32'h1;
        rx_left <= rx_left - 1 + int'(rx_add);
      end
      else
      begin
        RXF_RDATA <= ~RXF_RDATA;
        rx_left <= rx_left + int'(rx_add);
      end
    end
  end
endmodule

// ### tb_tcp_offload_demo_user_controller.sv
`timescale 1ns/10ps
module tb_tcp_offload_demo_user_controller
  import tou_pkg::*;
;
  logic        CLK, RST_B, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, TXF_WDATA, RXF_RDATA, bad_at, rd;
  logic        PACKET_SIZE_SWITCH, DIRECTION_SELECT_SWITCH, START_BUTTON, CORE_WR, CONNECTION_ACTIVE;
  logic [3:0]  CORE_ADDR;
  logic [63:0] CORE_WDATA, CORE_RDATA;
  logic        TXF_WREN, TXF_FULL, RXF_RDEN, RXF_EMPTY, VERIFY_FAIL_LED, IRQ, open_req, close_req, err, l0;
  logic [15:0] busy_len, rx_add;
  int          num_errors, n_checks, i, k, s0, w0;

  tou_ctrl #(.BLINK_CYCLES(4)) u_dut (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PACKET_SIZE_SWITCH(PACKET_SIZE_SWITCH), .DIRECTION_SELECT_SWITCH(DIRECTION_SELECT_SWITCH),
    .START_BUTTON(START_BUTTON), .CORE_WR(CORE_WR), .CORE_ADDR(CORE_ADDR), .CORE_WDATA(CORE_WDATA),
    .CORE_RDATA(CORE_RDATA), .CONNECTION_ACTIVE(CONNECTION_ACTIVE), .TXF_WREN(TXF_WREN),
    .TXF_WDATA(TXF_WDATA), .TXF_FULL(TXF_FULL), .RXF_RDEN(RXF_RDEN), .RXF_RDATA(RXF_RDATA),
    .RXF_EMPTY(RXF_EMPTY), .VERIFY_FAIL_LED(VERIFY_FAIL_LED), .IRQ(IRQ));
  tou_core_model u_core (.CLK(CLK), .RST_B(RST_B), .CORE_WR(CORE_WR), .CORE_ADDR(CORE_ADDR),
    .CORE_WDATA(CORE_WDATA), .CORE_RDATA(CORE_RDATA), .CONNECTION_ACTIVE(CONNECTION_ACTIVE),
    .TXF_WREN(TXF_WREN), .TXF_WDATA(TXF_WDATA), .TXF_FULL(TXF_FULL), .RXF_RDEN(RXF_RDEN),
    .RXF_RDATA(RXF_RDATA), .RXF_EMPTY(RXF_EMPTY), .open_req(open_req), .close_req(close_req),
    .busy_len(busy_len), .rx_add(rx_add), .bad_at(bad_at));

  // 250 MHz clock
  initial
  begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; pready, read data and error are all taken at the rising edge that ends the access
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge CLK);
      if (PREADY === 1'b1)
        break;
    end
    if (n == 20)
    begin
      num_errors++;
      print_verdict();
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic wait_st(input logic [3:0] s);
    int n;
    for (n = 0; n < 3000; n++)
    begin
      apb(1'b0, REG_STATUS, 32'h0);
      if (rd[3:0] === s)
        break;
    end
    if (n == 3000)
    begin
      num_errors++;
      print_verdict();
    end
  endtask

  task automatic pulse_open();
    @(posedge CLK);
    open_req <= 1'b1;
    @(posedge CLK);
    open_req <= 1'b0;
  endtask

  initial
  begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA, PACKET_SIZE_SWITCH, DIRECTION_SELECT_SWITCH} = '0;
    {START_BUTTON, open_req, close_req, rx_add, bad_at} = '0;
    busy_len = 16'd60;
    bad_at = 32'hffff_ffff;
    num_errors = 0;
    n_checks = 0;
    RST_B = 1'b0;
    repeat (16) @(posedge CLK);
    RST_B <= 1'b1;
    // reset state, map edges and mask register
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[3:0], ST_IDLE);
    chk(VERIFY_FAIL_LED, 1'b0);
    chk(u_core.regs[CORE_RST_ADDR], RST_ON_VAL);
    apb(1'b0, 8'h18, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    apb(1'b1, REG_IRQ_MASK, 32'hf);
    apb(1'b0, REG_IRQ_MASK, 32'h0);
    chk(rd, 32'hf);
    $display("test reset done");
    // start button runs parameter setup and core release
    @(posedge CLK);
    START_BUTTON <= 1'b1;
    repeat (2) @(posedge CLK);
    START_BUTTON <= 1'b0;
    wait_st(ST_OPEN_WAIT);
    chk(u_core.regs[CORE_SMAC_ADDR][47:0], 48'h0001_0203_0405);
    chk(u_core.regs[CORE_SIP_ADDR][31:0], {8'd192, 8'd168, 8'd7, 8'd42});
    chk(u_core.regs[CORE_SPORT_ADDR][15:0], 16'd4000);
    chk(u_core.regs[CORE_DIP_ADDR][31:0], {8'd192, 8'd168, 8'd7, 8'd25});
    chk(u_core.regs[CORE_RST_ADDR], 64'h0);
    $display("test start done");
    // transmit runs, standard then jumbo packets
    for (i = 0; i < 2; i++)
    begin
      PACKET_SIZE_SWITCH <= i[0];
      DIRECTION_SELECT_SWITCH <= 1'b1;
      busy_len <= (i == 0) ? 16'd60 : 16'd400;
      s0 = u_core.n_send;
      w0 = u_core.n_words;
      k = u_core.n_close;
      pulse_open();
      wait_st(ST_XFER_WAIT);
      wait_st(ST_OPEN_WAIT);
      chk(u_core.n_send - s0, 8);
      chk(u_core.n_close - k, 1);
      chk(u_core.regs[CORE_TDL_ADDR], 64'h1_0000_0000);
      chk(u_core.regs[CORE_PKL_ADDR], (i == 0) ? 64'd1456 : 64'd8960);
      chk(u_core.n_order, 0);
      chk(u_core.n_err, 0);
      chk(u_core.n_words - w0 > ((i == 0) ? 364 : 2240), 1);
      chk(IRQ, 1'b1);
      apb(1'b0, REG_IRQ_STAT, 32'h0);
      chk(rd[3:0], 4'b0110);
      @(negedge CLK);
      chk(IRQ, 1'b0);
      $display("test transmit done");
    end
    // receive run: clean words, then one corrupted word
    DIRECTION_SELECT_SWITCH <= 1'b0;
    pulse_open();
    wait_st(ST_CLOSE_WAIT);
    for (i = 0; i < 2; i++)
    begin
      bad_at <= (i == 0) ? 32'hffff_ffff : 32'd45;
      rx_add <= (i == 0) ? 16'd40 : 16'd10;
      @(posedge CLK);
      rx_add <= 16'd0;
      for (k = 0; k < 200; k++)
      begin
        apb(1'b0, REG_RX_WORDS, 32'h0);
        if (rd === ((i == 0) ? 32'd40 : 32'd50))
          break;
      end
      chk(k < 200, 1);
      apb(1'b0, REG_STATUS, 32'h0);
      chk(rd[7], i[0]);
    end
    l0 = VERIFY_FAIL_LED;
    k = 0;
    repeat (40)
    begin
      @(negedge CLK);
      if (VERIFY_FAIL_LED !== l0)
        k++;
      l0 = VERIFY_FAIL_LED;
    end
    chk(k >= 2, 1);
    @(posedge CLK);
    close_req <= 1'b1;
    @(posedge CLK);
    close_req <= 1'b0;
    wait_st(ST_OPEN_WAIT);
    apb(1'b0, REG_IRQ_STAT, 32'h0);
    chk(rd[3:0], 4'b1011);
    chk(u_core.n_wr_busy, 0);
    $display("test receive done");
    print_verdict();
  end
endmodule
